// *** icr_pkg.sv ***
package icr_pkg;

    // Register word addresses on the plain register port
    localparam logic [7:0] ADDR_CTRL = 8'h1D;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h1E;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h1F;
    localparam logic [7:0] ADDR_EXT_CFG = 8'h20;

    // Control and status register fields
    localparam int BIT_REQ_ACTIVE = 15;
    localparam int BIT_PRIO_HI = 14;
    localparam int BIT_PRIO_LO = 13;
    localparam int BIT_VEC_HI = 12;
    localparam int BIT_VEC_LO = 6;
    localparam int BIT_GLOBAL_DIS = 5;
    localparam int BIT_RSVD_ONE = 4;
    localparam int BIT_PIN_LEVEL = 2;
    localparam int BIT_EDGE_SEL = 0;
    localparam logic [15:0] CTRL_RESET = 16'h101C;
    localparam logic [1:0] PRIO_RESET = 2'h0;
    localparam logic [6:0] VEC_RESET = 7'h40;
    localparam logic GLOBAL_DIS_RESET = 1'b0;
    localparam logic EDGE_SEL_RESET = 1'b0;

    // Event status and mask layout
    localparam int EVT_W = 2;
    localparam int EVT_TAKEN = 0;
    localparam int EVT_EXT_PIN = 1;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

    // External pin enable register (bit 0); disabled after reset
    localparam int BIT_EXT_EN = 0;
    localparam logic EXT_EN_RESET = 1'b0;

    // Fixed-priority core requests enabled from reset onward:
    // illegal instruction, stack overflow, misaligned long, SW 0..3, SW low priority
    localparam int FIXED_W = 8;
    localparam logic [FIXED_W-1:0] FIXED_EN_RESET = 8'hFF;

    // Vector number presented to the core during reset
    localparam logic [6:0] RESET_VECTOR_NUM = 7'h00;

    typedef enum logic [1:0] {
        RST_HOLD,
        RST_REL1,
        RST_RUN
    } icr_rst_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } icr_bus_s;

    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [6:0] vector;
    } icr_req_s;

endpackage : icr_pkg

// *** icr_pin_detect.sv ***
`timescale 1ns/1ps
// Turns the active-low external request pin into a request level.
module icr_pin_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_n,
    input wire logic edge_sel,
    input wire logic low_power,
    input wire logic ack,
    output logic req,
    output logic level
);

    logic prev_q;
    logic prev_d;
    logic latch_q;
    logic latch_d;
    logic use_edge;

    // Stop and wait force level sensing
    assign use_edge = edge_sel && !low_power;

    always_comb begin
        prev_d = pin_n;
        latch_d = latch_q;
        if (!use_edge) begin
            latch_d = 1'b0;
        end else if (prev_q && !pin_n) begin
            latch_d = 1'b1;
        end else if (ack) begin
            latch_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_q <= 1'b1;
            latch_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            latch_q <= latch_d;
        end
    end

    assign req = use_edge ? latch_q : !pin_n;
    assign level = pin_n;

endmodule : icr_pin_detect

// *** icr_ctrl.sv ***
`timescale 1ns/1ps
// Function
// - Bit 15 shows request driven to core
// - Priority field captured when interrupt is taken
// - Vector field captured when interrupt is taken
// - Global disable bit blocks all core requests
// - Bit 4 reads one, bits 3,1 zero
// - Bit 2 shows external pin level
// - Bit 0 selects low level or falling edge
// - Stop or wait forces level sensing
// - Reset vector until second edge after release
// - After reset only fixed core requests enabled
module icr_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic req_valid,
    input wire logic [1:0] req_level,
    input wire logic [6:0] req_vector,
    input wire logic core_taken,
    input wire logic ext_request_pin_n,
    input wire logic stop_mode,
    input wire logic wait_mode,
    output logic core_irq,
    output logic [1:0] core_new_level,
    output logic [6:0] core_vector,
    output logic reset_vector_active,
    output logic ext_irq_req,
    output logic [icr_pkg::FIXED_W-1:0] fixed_core_enable,
    output logic irq
);

    icr_pkg::icr_bus_s bus;
    icr_pkg::icr_req_s req;

    logic [1:0] prio_q;
    logic [1:0] prio_d;
    logic [6:0] vec_q;
    logic [6:0] vec_d;
    logic dis_q;
    logic dis_d;
    logic edge_q;
    logic edge_d;
    logic ext_en_q;
    logic ext_en_d;
    logic [icr_pkg::EVT_W-1:0] evt_q;
    logic [icr_pkg::EVT_W-1:0] evt_d;
    logic [icr_pkg::EVT_W-1:0] mask_q;
    logic [icr_pkg::EVT_W-1:0] mask_d;
    logic [icr_pkg::FIXED_W-1:0] fixed_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    icr_pkg::icr_rst_e rst_state_q;
    icr_pkg::icr_rst_e rst_state_d;

    logic pin_req;
    logic pin_level;
    logic ext_req_prev_q;
    logic taken;
    logic [icr_pkg::EVT_W-1:0] evt_set;

    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign req = '{valid: req_valid, level: req_level, vector: req_vector};

    function automatic logic hit(input icr_pkg::icr_bus_s b, input logic [7:0] a);
        hit = b.addr == a;
    endfunction : hit

    icr_pin_detect u_pin (
        .clk(clk),
        .rst_n(rst_n),
        .pin_n(ext_request_pin_n),
        .edge_sel(edge_q),
        .low_power(stop_mode || wait_mode),
        .ack(core_taken),
        .req(pin_req),
        .level(pin_level)
    );

    // External request goes to the priority logic only when enabled
    assign ext_irq_req = pin_req && ext_en_q;

    // Core request path
    assign core_irq = req.valid && !dis_q && rst_state_q == icr_pkg::RST_RUN;
    assign core_new_level = req.level;
    assign core_vector = reset_vector_active ? icr_pkg::RESET_VECTOR_NUM : req.vector;
    assign taken = core_taken && core_irq;

    // Reset vector sequencing
    always_comb begin
        rst_state_d = rst_state_q;
        unique case (rst_state_q)
            icr_pkg::RST_HOLD: rst_state_d = icr_pkg::RST_REL1;
            icr_pkg::RST_REL1: rst_state_d = icr_pkg::RST_RUN;
            icr_pkg::RST_RUN: rst_state_d = icr_pkg::RST_RUN;
            default: rst_state_d = icr_pkg::RST_HOLD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_state_q <= icr_pkg::RST_HOLD;
        end else begin
            rst_state_q <= rst_state_d;
        end
    end

    assign reset_vector_active = !rst_n || rst_state_q != icr_pkg::RST_RUN;

    // Captured level and vector change only on entry to a service routine
    always_comb begin
        prio_d = prio_q;
        vec_d = vec_q;
        if (taken) begin
            prio_d = req.level;
            vec_d = req.vector;
        end
    end

    // Writable control bits; read-only fields never take bus data
    always_comb begin
        dis_d = dis_q;
        edge_d = edge_q;
        ext_en_d = ext_en_q;
        mask_d = mask_q;
        if (bus.wr && hit(bus, icr_pkg::ADDR_CTRL)) begin
            dis_d = bus.wdata[icr_pkg::BIT_GLOBAL_DIS];
            edge_d = bus.wdata[icr_pkg::BIT_EDGE_SEL];
        end
        if (bus.wr && hit(bus, icr_pkg::ADDR_EXT_CFG)) begin
            ext_en_d = bus.wdata[icr_pkg::BIT_EXT_EN];
        end
        if (bus.wr && hit(bus, icr_pkg::ADDR_EVT_MASK)) begin
            mask_d = bus.wdata[icr_pkg::EVT_W-1:0];
        end
    end

    // Sticky events: a set in the clearing cycle survives
    always_comb begin
        evt_set = '0;
        evt_set[icr_pkg::EVT_TAKEN] = taken;
        evt_set[icr_pkg::EVT_EXT_PIN] = ext_irq_req && !ext_req_prev_q;
        evt_d = evt_q;
        if (bus.wr && hit(bus, icr_pkg::ADDR_EVT_STATUS)) begin
            evt_d = evt_q & ~bus.wdata[icr_pkg::EVT_W-1:0];
        end
        evt_d = evt_d | evt_set;
    end

    // Read data, valid only in the cycle after the strobe
    always_comb begin
        rdata_d = 16'h0000;
        if (bus.rd) begin
            if (hit(bus, icr_pkg::ADDR_CTRL)) begin
                rdata_d[icr_pkg::BIT_REQ_ACTIVE] = core_irq;
                rdata_d[icr_pkg::BIT_PRIO_HI:icr_pkg::BIT_PRIO_LO] = prio_q;
                rdata_d[icr_pkg::BIT_VEC_HI:icr_pkg::BIT_VEC_LO] = vec_q;
                rdata_d[icr_pkg::BIT_GLOBAL_DIS] = dis_q;
                rdata_d[icr_pkg::BIT_RSVD_ONE] = 1'b1;
                rdata_d[icr_pkg::BIT_PIN_LEVEL] = pin_level;
                rdata_d[icr_pkg::BIT_EDGE_SEL] = edge_q;
            end else if (hit(bus, icr_pkg::ADDR_EVT_STATUS)) begin
                rdata_d[icr_pkg::EVT_W-1:0] = evt_q;
            end else if (hit(bus, icr_pkg::ADDR_EVT_MASK)) begin
                rdata_d[icr_pkg::EVT_W-1:0] = mask_q;
            end else if (hit(bus, icr_pkg::ADDR_EXT_CFG)) begin
                rdata_d[icr_pkg::BIT_EXT_EN] = ext_en_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prio_q <= icr_pkg::PRIO_RESET;
            vec_q <= icr_pkg::VEC_RESET;
            dis_q <= icr_pkg::GLOBAL_DIS_RESET;
            edge_q <= icr_pkg::EDGE_SEL_RESET;
            ext_en_q <= icr_pkg::EXT_EN_RESET;
            evt_q <= icr_pkg::EVT_RESET;
            mask_q <= icr_pkg::EVT_RESET;
            fixed_q <= icr_pkg::FIXED_EN_RESET;
            rdata_q <= 16'h0000;
            ext_req_prev_q <= 1'b0;
        end else begin
            prio_q <= prio_d;
            vec_q <= vec_d;
            dis_q <= dis_d;
            edge_q <= edge_d;
            ext_en_q <= ext_en_d;
            evt_q <= evt_d;
            mask_q <= mask_d;
            fixed_q <= fixed_q;
            rdata_q <= rdata_d;
            ext_req_prev_q <= ext_irq_req;
        end
    end

    assign reg_rdata = rdata_q;
    assign fixed_core_enable = fixed_q;
    assign irq = |(evt_q & mask_q);

    // Shadow of the disable bit, rebuilt from bus writes alone
    logic chk_dis_q;
    logic chk_dis_d;

    always_comb begin
        chk_dis_d = chk_dis_q;
        if (reg_wr && reg_addr == icr_pkg::ADDR_CTRL) begin
            chk_dis_d = reg_wdata[icr_pkg::BIT_GLOBAL_DIS];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chk_dis_q <= icr_pkg::GLOBAL_DIS_RESET;
        end else begin
            chk_dis_q <= chk_dis_d;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_REQ_BIT: assert property (
        reg_rd && reg_addr == icr_pkg::ADDR_CTRL |=> reg_rdata[15] == $past(core_irq))
        else $error("Request bit does not follow core request");

    AST_PRIO_CAPTURE: assert property (
        core_taken && core_irq |=> prio_q == $past(req_level))
        else $error("Priority not captured on taken");

    AST_PRIO_HOLD: assert property (
        !(core_taken && core_irq) |=> $stable(prio_q))
        else $error("Priority changed without taken");

    AST_VEC_CAPTURE: assert property (
        core_taken && core_irq ##1 !(core_taken && core_irq)
        ##1 reg_rd && reg_addr == icr_pkg::ADDR_CTRL
        |=> reg_rdata[12:6] == $past(req_vector, 3))
        else $error("Vector not readable after taken");

    AST_GLOBAL_DIS: assert property (
        chk_dis_q |-> !core_irq)
        else $error("Core request passed while disabled");

    AST_RESERVED: assert property (
        reg_rd && reg_addr == icr_pkg::ADDR_CTRL
        |=> reg_rdata[4] && !reg_rdata[3] && !reg_rdata[1])
        else $error("Reserved bits read wrong");

    AST_PIN_LEVEL: assert property (
        reg_rd && reg_addr == icr_pkg::ADDR_CTRL |=> reg_rdata[2] == $past(ext_request_pin_n))
        else $error("Pin level bit wrong");

    AST_LOW_POWER_LEVEL: assert property (
        (stop_mode || wait_mode || !edge_q) && ext_en_q |-> ext_irq_req == !ext_request_pin_n)
        else $error("Level sensing not applied");

    AST_RST_VECTOR: assert property (
        $rose(rst_n) |-> reset_vector_active ##1 reset_vector_active ##1 !reset_vector_active)
        else $error("Reset vector window wrong");

    AST_RO_WRITE: assert property (
        reg_wr && reg_addr == icr_pkg::ADDR_CTRL && !(core_taken && core_irq)
        |=> prio_q == $past(prio_q) && vec_q == $past(vec_q))
        else $error("Write altered read-only field");

    AST_STICKY: assert property (
        evt_set != '0 |=> (evt_q & $past(evt_set)) == $past(evt_set))
        else $error("Event lost");

    // Reset vector window and request gating
    AST_CORE_IRQ_RST: assert property (
        reset_vector_active |-> !core_irq)
        else $error("Core request during reset vector window");

    AST_RST_VEC_NUM: assert property (
        reset_vector_active |-> core_vector == icr_pkg::RESET_VECTOR_NUM)
        else $error("Reset vector number not presented");

    AST_RST_SEQ: assert property (
        !reset_vector_active |=> !reset_vector_active)
        else $error("Reset vector returned without reset");

    AST_REQ_IN_RUN: assert property (
        !chk_dis_q && !reset_vector_active |-> core_irq == req_valid)
        else $error("Core request does not follow waiting request");

    // Captured fields, new level and writable bit readback
    AST_NEW_LEVEL: assert property (
        core_new_level == req_level)
        else $error("New level not presented to core");

    AST_VEC_TAKE: assert property (
        core_taken && core_irq |=> vec_q == $past(req_vector))
        else $error("Vector not captured on taken");

    AST_VEC_HOLD: assert property (
        !(core_taken && core_irq) |=> $stable(vec_q))
        else $error("Vector changed without taken");

    AST_RW_READBACK: assert property (
        reg_rd && reg_addr == icr_pkg::ADDR_CTRL
        |=> reg_rdata[5] == $past(chk_dis_q) && reg_rdata[0] == $past(edge_q))
        else $error("Writable control bits read back wrong");

    // External pin, fixed enables, event bits and idle read data
    AST_EDGE_LATCH: assert property (
        ext_en_q && edge_q && !stop_mode && !wait_mode && $fell(ext_request_pin_n)
        |=> ext_irq_req || !(ext_en_q && edge_q && !stop_mode && !wait_mode))
        else $error("Falling edge not latched");

    AST_LP_NO_LATCH: assert property (
        (stop_mode || wait_mode) && ext_request_pin_n |-> !ext_irq_req)
        else $error("Latched edge seen in stop or wait");

    AST_EXT_OFF: assert property (
        !ext_en_q |-> !ext_irq_req)
        else $error("External request passed while not enabled");

    AST_FIXED_EN: assert property (
        fixed_core_enable == icr_pkg::FIXED_EN_RESET)
        else $error("Fixed core requests not enabled");

    AST_EXT_EVENT: assert property (
        $rose(ext_irq_req) |=> evt_q[icr_pkg::EVT_EXT_PIN])
        else $error("External request event not recorded");

    AST_RDATA_IDLE: assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("Read data outside read cycle");

    AST_TAKEN_EVENT: assert property (
        core_taken && core_irq |=> evt_q[icr_pkg::EVT_TAKEN])
        else $error("Taken event not recorded");

    AST_EVT_CLEAR: assert property (
        reg_wr && reg_addr == icr_pkg::ADDR_EVT_STATUS && reg_wdata[icr_pkg::EVT_TAKEN]
        && !(core_taken && core_irq) |=> !evt_q[icr_pkg::EVT_TAKEN])
        else $error("Taken event not cleared by write of one");

endmodule : icr_ctrl

// *** icr_core_model.sv ***
`timescale 1ns/1ps
// Processor core: enters a service routine a set number of cycles after a request
module icr_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic core_irq,
    input wire logic reset_vector_active,
    input wire logic [3:0] take_delay,
    output logic core_taken
);
    logic armed_q;
    logic [3:0] cnt_q;
    always_ff @(posedge clk) begin
        core_taken <= 1'b0;
        if (!rst_n || reset_vector_active || !core_irq) begin
            armed_q <= 1'b1;
            cnt_q <= 4'h0;
        end else if (armed_q) begin
            if (cnt_q == take_delay) begin
                core_taken <= 1'b1;
                armed_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule : icr_core_model

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic clk, rst_n, reg_wr, reg_rd, req_valid, pin_n, stop_m, wait_m;
    logic core_taken, core_irq, rva, ext_req, irq;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [1:0] req_level, core_new_level;
    logic [6:0] req_vector, core_vector;
    logic [3:0] dly;
    logic [icr_pkg::FIXED_W-1:0] fixed_en;
    int fails = 0;
    int n_tests = 0;

    icr_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
        .req_level(req_level), .req_vector(req_vector), .core_taken(core_taken),
        .ext_request_pin_n(pin_n), .stop_mode(stop_m), .wait_mode(wait_m),
        .core_irq(core_irq), .core_new_level(core_new_level), .core_vector(core_vector),
        .reset_vector_active(rva), .ext_irq_req(ext_req), .fixed_core_enable(fixed_en),
        .irq(irq));
    icr_core_model core (.clk(clk), .rst_n(rst_n), .core_irq(core_irq),
        .reset_vector_active(rva), .take_delay(dly), .core_taken(core_taken));

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk) reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk) reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string nm);
        @(posedge clk) reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
        `CHK(nm, e, d)
    endtask : rchk
    // Hold the request until the core model enters its routine
    task automatic take(input logic [1:0] l, input logic [6:0] v);
        int i;
        i = 0;
        @(posedge clk) req_valid <= 1'b1;
        req_level <= l;
        req_vector <= v;
        while (core_taken !== 1'b1 && i < 30) begin
            @(posedge clk);
            #1 i++;
        end
        `CHK("taken", 1'b1, core_taken)
        `CHK("new_level", l, core_new_level)
        `CHK("new_vector", v, core_vector)
        @(posedge clk) req_valid <= 1'b0;
    endtask : take
    task automatic pin(input logic v);
        @(posedge clk) pin_n <= v;
        repeat (3) @(posedge clk);
        #1;
    endtask : pin
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000;
        req_valid = 1'b0; req_level = 2'h0; req_vector = 7'h00; pin_n = 1'b1;
        stop_m = 1'b0; wait_m = 1'b0; dly = 4'h0;
        repeat (2) @(posedge clk);
        #1 `CHK("rv_in_reset", 1'b1, rva)
        `CHK("rv_number", 7'h00, core_vector)
        @(posedge clk) rst_n <= 1'b1;
        @(posedge clk);
        #1 `CHK("rv_edge1", 1'b1, rva)
        @(posedge clk);
        #1 `CHK("rv_edge2", 1'b0, rva)
        `CHK("fixed_en", 8'hFF, fixed_en)
        rchk(icr_pkg::ADDR_CTRL, 16'h1014, "ctrl_rst");
        rchk(icr_pkg::ADDR_EVT_STATUS, 16'h0000, "stat_rst");
        rchk(icr_pkg::ADDR_EVT_MASK, 16'h0000, "mask_rst");
        rchk(icr_pkg::ADDR_EXT_CFG, 16'h0000, "ext_rst");
        rchk(8'h21, 16'h0000, "unmapped");
        $display("reset test done");
        wr(icr_pkg::ADDR_CTRL, 16'hFFFF);
        rchk(icr_pkg::ADDR_CTRL, 16'h1035, "ctrl_wr");
        @(posedge clk) dly <= 4'hF;
        req_valid <= 1'b1;
        req_level <= 2'h1;
        req_vector <= 7'h15;
        rchk(icr_pkg::ADDR_CTRL, 16'h1035, "dis_bit15");
        `CHK("dis_irq", 1'b0, core_irq)
        wr(icr_pkg::ADDR_CTRL, 16'h0000);
        `CHK("en_irq", 1'b1, core_irq)
        rchk(icr_pkg::ADDR_CTRL, 16'h9014, "req_bit15");
        take(2'h1, 7'h15);
        rchk(icr_pkg::ADDR_CTRL, {3'b001, 7'h15, 6'h14}, "cap1");
        $display("disable test done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) dly <= 4'(k * 3);
            take(2'(k), 7'h7F - 7'(k * 42));
            rchk(icr_pkg::ADDR_CTRL, {1'b0, 2'(k), 7'h7F - 7'(k * 42), 6'h14}, "cap_k");
        end
        `CHK("irq_masked", 1'b0, irq)
        rchk(icr_pkg::ADDR_EVT_STATUS, 16'h0001, "stat_taken");
        wr(icr_pkg::ADDR_EVT_MASK, 16'h0001);
        `CHK("irq_on", 1'b1, irq)
        wr(icr_pkg::ADDR_EVT_STATUS, 16'h0001);
        `CHK("irq_clr", 1'b0, irq)
        rchk(icr_pkg::ADDR_EVT_STATUS, 16'h0000, "stat_clr");
        $display("capture test done");
        wr(icr_pkg::ADDR_EXT_CFG, 16'h0001);
        pin(1'b0);
        `CHK("lvl_req", 1'b1, ext_req)
        rchk(icr_pkg::ADDR_CTRL, {3'b011, 7'h7F - 7'd126, 6'h10}, "pin_low");
        pin(1'b1);
        `CHK("lvl_idle", 1'b0, ext_req)
        rchk(icr_pkg::ADDR_EVT_STATUS, 16'h0002, "stat_ext");
        wr(icr_pkg::ADDR_CTRL, 16'h0001);
        for (int m = 0; m < 2; m++) begin
            pin(1'b0);
            pin(1'b1);
            `CHK("edge_latch", 1'b1, ext_req)
            @(posedge clk) stop_m <= (m == 0);
            wait_m <= (m == 1);
            repeat (3) @(posedge clk);
            #1 `CHK("lp_level", 1'b0, ext_req)
            @(posedge clk) stop_m <= 1'b0;
            wait_m <= 1'b0;
        end
        $display("pin test done");
        @(posedge clk) rst_n <= 1'b0;
        req_valid <= 1'b1;
        @(posedge clk);
        #1 `CHK("rv_mid", 1'b1, rva)
        `CHK("rv_mid_num", 7'h00, core_vector)
        @(posedge clk) rst_n <= 1'b1;
        @(posedge clk);
        #1 `CHK("rv_mid_edge1", 1'b1, rva)
        `CHK("irq_mid_edge1", 1'b0, core_irq)
        @(posedge clk);
        #1 `CHK("rv_mid_edge2", 1'b0, rva)
        `CHK("irq_mid_run", 1'b1, core_irq)
        rchk(icr_pkg::ADDR_CTRL, 16'h9014, "ctrl_mid");
        @(posedge clk) req_valid <= 1'b0;
        $display("second reset test done");
        conclude();
    end
endmodule : tb_top
